// ### verification/pin_board.sv
// board model: resolves each pin from device drive, board drive and pull-up
`timescale 1ns/100ps
module pin_board (
  input wire logic clk_in,
  input wire logic [33:0] pin_out_in,
  input wire logic [33:0] pin_oe_in,
  input wire logic [33:0] pullup_en_in,
  input wire logic [33:0] drive_en_in,
  input wire logic [33:0] drive_val_in,
  output logic [33:0] level_out
);
  logic [33:0] float_val = 34'h0;
  // an unheld line wanders every cycle so a stale level cannot pass
  always @(posedge clk_in) float_val <= ~float_val;
  assign level_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & drive_en_in & drive_val_in)
    | (~pin_oe_in & ~drive_en_in & (pullup_en_in | float_val));
endmodule // pin_board

// ### verification/pin_port_chk.sv
// assertion checker for the pin port bus and data paths
`timescale 1ns/100ps
module pin_port_chk
  import pin_port_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic clk_en_in,
  input wire pin_port_pkg::bus_req_t bus_in,
  input wire logic write_protect_unlock_in,
  input wire logic [31:0] bus_rdata_out,
  input wire logic bus_ack_out,
  input wire logic [33:0] pin_in,
  input wire logic [33:0] pin_out,
  input wire logic [33:0] pin_oe_out,
  input wire logic [33:0] pullup_en_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_take;
    bus_in.req && clk_en_in;
  endsequence
  sequence s_quiet;
    !bus_in.req && clk_en_in;
  endsequence
  sequence s_wr(logic [15:0] a);
    s_take ##0 (bus_in.wr && bus_in.wide && bus_in.addr == a);
  endsequence
  property p_ack;
    s_take |=> bus_ack_out;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack after request");
  property p_wr_zero;
    s_take ##0 bus_in.wr |=> bus_ack_out && bus_rdata_out == 32'h0;
  endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("write answer not zero");
  property p_set;
    s_wr(OFS_A_SET) ##1 s_quiet [*2] |=>
      (pin_out[31:0] & $past(bus_in.wdata, 3)) == $past(bus_in.wdata, 3);
  endproperty
  a_set: assert property (p_set) else $error("set bits not driven high");
  property p_clear;
    s_wr(OFS_A_CLEAR) ##1 s_quiet [*2] |=> (pin_out[31:0] & $past(bus_in.wdata, 3)) == 32'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("clear bits still high");
  property p_locked;
    s_quiet [*3] ##1 (s_take ##0 bus_in.wr && !write_protect_unlock_in && bus_in.addr == OFS_A_DIR)
      ##1 s_quiet [*2] |=> pin_oe_out[31:0] == $past(pin_oe_out[31:0], 3);
  endproperty
  a_locked: assert property (p_locked) else $error("locked direction write took");
  property p_dir;
    s_wr(OFS_A_DIR) ##0 write_protect_unlock_in ##1 s_quiet [*2] |=>
      pin_oe_out[31:0] == $past(bus_in.wdata, 3);
  endproperty
  a_dir: assert property (p_dir) else $error("direction not applied");
  property p_read;
    $stable(pin_in) [*6] ##0 s_take ##0 (!bus_in.wr && bus_in.wide && bus_in.addr == OFS_A_DATA)
      |=> bus_rdata_out == $past(pin_in[31:0]);
  endproperty
  a_read: assert property (p_read) else $error("data read not pin level");
  property p_reset;
    $rose(nrst_in) |-> pullup_en_out == 34'h3_FFFF_FFFF && pin_oe_out == 34'h0 && !bus_ack_out;
  endproperty
  a_reset: assert property (p_reset) else $error("bad value after reset");
endmodule // pin_port_chk

bind pin_port pin_port_chk pin_port_chk_i (.clk_in(clk_in), .nrst_in(nrst_in),
  .clk_en_in(clk_en_in), .bus_in(bus_in), .write_protect_unlock_in(write_protect_unlock_in),
  .bus_rdata_out(bus_rdata_out), .bus_ack_out(bus_ack_out), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe_out(pin_oe_out), .pullup_en_out(pullup_en_out));

// ### verification/tb.sv
// self-checking bench for the pin port
`timescale 1ns/100ps
module tb;
  import pin_port_pkg::*;
  typedef struct packed {
    logic wr; logic wide; logic unl; logic [15:0] addr; logic [31:0] wdata; logic [31:0] exp;
  } row_t;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic clk_en_in = 1'b1;
  logic unl = 1'b0;
  bus_req_t bus_in = '0;
  periph_pin_t [33:0] periph = '0;
  logic [31:0] rdata, mask;
  logic ack, ext1, ext2, nmi;
  logic [33:0] pout, poe, pu, lvl;
  logic [33:0] qlo, qhi;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  row_t rows [32] = '{
    '{0,1,0,OFS_A_DIR,0,0}, '{1,1,0,OFS_A_DIR,32'hFFFF_0000,0}, '{0,1,0,OFS_A_DIR,0,0},
    '{1,1,1,OFS_A_DIR,32'hFF,0}, '{0,1,0,OFS_A_DIR,0,32'hFF},
    '{1,1,0,OFS_A_SET,32'h5,0}, '{0,1,0,OFS_A_DATA,0,32'h5},
    '{1,1,0,OFS_A_CLEAR,32'h4,0}, '{0,1,0,OFS_A_DATA,0,32'h1},
    '{1,1,0,OFS_A_INVERT,32'h3,0}, '{0,1,0,OFS_A_DATA,0,32'h2},
    '{1,0,0,OFS_A_SET,32'h80,0}, '{0,1,0,OFS_A_DATA,0,32'h82},
    '{1,1,0,OFS_A_DATA,32'hA,0}, '{0,1,0,OFS_A_DATA,0,32'hA},
    '{1,0,0,OFS_IRQ1_SEL,32'h3,0}, '{0,1,0,OFS_IRQ1_SEL,0,0},
    '{1,0,1,OFS_IRQ1_SEL,32'h3,0}, '{0,1,0,OFS_IRQ1_SEL,0,32'h3},
    '{1,0,1,OFS_NMI_SEL,32'h1,0}, '{0,1,0,OFS_NMI_SEL,0,32'h1},
    '{1,1,1,OFS_WAKE_SEL,32'h2,0}, '{0,1,0,OFS_WAKE_SEL,0,32'h2},
    '{1,1,1,OFS_A_PULLUP_OFF,32'h1,0}, '{0,1,0,OFS_A_PULLUP_OFF,0,32'h1},
    '{1,1,1,16'h6F8E,32'h1234_5678,0}, '{0,1,0,16'h6F8E,0,0},
    '{1,1,1,OFS_B_DIR,32'h3,0}, '{1,1,0,OFS_B_SET,32'h7,0}, '{0,1,0,OFS_B_DATA,0,32'h3},
    '{1,1,1,OFS_A_QUAL_LO,32'h2,0}, '{1,1,1,OFS_A_QUAL_HI,32'h1,0}};
  always #4 clk_in = ~clk_in;
  pin_port pin_port_i (.clk_in(clk_in), .nrst_in(nrst_in), .clk_en_in(clk_en_in),
    .bus_in(bus_in), .write_protect_unlock_in(unl), .bus_rdata_out(rdata), .bus_ack_out(ack),
    .pin_in(lvl), .pin_out(pout), .pin_oe_out(poe), .pullup_en_out(pu), .periph_in(periph),
    .periph_pin_level_out(), .qual_sel_lo_out(qlo), .qual_sel_hi_out(qhi), .port_control_out(),
    .external_interrupt_one_out(ext1), .external_interrupt_two_out(ext2),
    .external_nonmaskable_interrupt_out(nmi), .low_power_wake_mask_out(mask));
  pin_board pin_board_i (.clk_in(clk_in), .pin_out_in(pout), .pin_oe_in(poe),
    .pullup_en_in(pu), .drive_en_in(34'h3_FFFF_FFFF), .drive_val_in(34'h0), .level_out(lvl));
  task automatic tally_and_finish;
    $display("counts: mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one request, answer taken one cycle later, then idle while pins settle
  task automatic bus(input row_t r);
    @(posedge clk_in) #1;
    unl = r.unl;
    bus_in = '{1'b1, r.wr, r.wide, r.addr, r.wdata};
    @(posedge clk_in) #1;
    bus_in.req = 1'b0;
    if (!r.wr) chk(34'(rdata), 34'(r.exp));
    repeat (8) @(posedge clk_in);
    #1;
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (20) @(posedge clk_in);
    #1 nrst_in = 1'b1;
    foreach (rows[i]) bus(rows[i]);
    chk(34'(mask), 34'h2);
    chk(pu, 34'h3_FFFF_FFFE);
    chk(34'({ext1, ext2, nmi}), 34'h5);
    chk(qlo, 34'h0_0001_0000);
    chk(qhi, 34'h0_0000_0001);
    bus('{1,1,0,OFS_A_CLEAR,32'h8,0});
    chk(34'(ext1), 34'h0);
    for (int s = 1; s < 4; s++) begin
      periph[16] = '{3'(1 << (s - 1)), 3'(1 << (s - 1))};
      bus('{1,1,1,OFS_A_FUNC_HI,32'(s),0});
      chk(34'({pout[16], poe[16]}), 34'h3);
    end
    bus('{1,1,1,OFS_A_FUNC_HI,0,0});
    chk(34'(poe[16]), 34'h0);
    // frozen clock enable: the set must not land
    clk_en_in = 1'b0;
    bus('{1,1,0,OFS_A_SET,32'h10,0});
    clk_en_in = 1'b1;
    bus('{0,1,0,OFS_A_DATA,0,32'h2});
    periph[32] = '{3'h1, 3'h1};
    bus('{1,1,1,OFS_B_FUNC_LO,32'h1,0});
    chk(34'({pout[32], poe[32]}), 34'h0);
    periph[32] = '{3'h0, 3'h1};
    repeat (2) @(posedge clk_in);
    #1;
    chk(34'({pout[32], poe[32]}), 34'h1);
    @(posedge clk_in) #1 nrst_in = 1'b0;
    repeat (3) @(posedge clk_in);
    #1 nrst_in = 1'b1;
    bus('{0,1,0,OFS_A_DIR,0,0});
    chk(pu, 34'h3_FFFF_FFFF);
    tally_and_finish();
  end
endmodule // tb

// ### verilog/pin_port.sv
// pin multiplexer and data port with its register file
`timescale 1ns/100ps
module pin_port #(
  parameter int NUM_PINS = 34,
  parameter int TWO_WIRE_PIN_A = 32,
  parameter int TWO_WIRE_PIN_B = 33
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic clk_en_in,
  input wire pin_port_pkg::bus_req_t bus_in,
  input wire logic write_protect_unlock_in,
  output logic [31:0] bus_rdata_out,
  output logic bus_ack_out,
  input wire logic [33:0] pin_in,
  output logic [33:0] pin_out,
  output logic [33:0] pin_oe_out,
  output logic [33:0] pullup_en_out,
  input wire pin_port_pkg::periph_pin_t [33:0] periph_in,
  output logic [33:0] periph_pin_level_out,
  output logic [33:0] qual_sel_lo_out,
  output logic [33:0] qual_sel_hi_out,
  output logic [63:0] port_control_out,
  output logic external_interrupt_one_out,
  output logic external_interrupt_two_out,
  output logic external_nonmaskable_interrupt_out,
  output logic [31:0] low_power_wake_mask_out
);
  import pin_port_pkg::*;

  // configuration state
  logic [31:0] a_control, b_control;
  logic [31:0] a_qual_lo, a_qual_hi, b_qual_lo;
  logic [31:0] a_func_lo, a_func_hi, b_func_lo;
  logic [31:0] a_dir, b_dir, a_pullup_off, b_pullup_off;
  logic [31:0] a_latch, b_latch;
  logic [4:0] irq1_sel, irq2_sel, nmi_sel;
  logic [31:0] wakeup_sel;
  // three-stage pin synchroniser
  logic [33:0] sync1, sync2, sync3, pin_level;

  // word-lane write merge: 16-bit access at odd word hits the upper half
  function automatic logic [31:0] merge(input logic [31:0] old, input bus_req_t r);
    logic [31:0] res;
    res = old;
    if (r.wide) begin
      res = r.wdata;
    end else if (r.addr[0]) begin
      res[31:16] = r.wdata[15:0];
    end else begin
      res[15:0] = r.wdata[15:0];
    end
    return res;
  endfunction

  // 32-bit value placed as a set/clear/invert mask (zero lane when 16-bit)
  function automatic logic [31:0] wmask(input bus_req_t r);
    logic [31:0] res;
    res = RST_WORD;
    if (r.wide) begin
      res = r.wdata;
    end else if (r.addr[0]) begin
      res[31:16] = r.wdata[15:0];
    end else begin
      res[15:0] = r.wdata[15:0];
    end
    return res;
  endfunction

  function automatic logic hit(input bus_req_t r, input logic [15:0] ofs);
    return r.req && ({r.addr[15:1], 1'b0} == ofs);
  endfunction

  wire bus_wr = bus_in.req && bus_in.wr && clk_en_in;
  wire prot_ok = write_protect_unlock_in;
  wire cfg_wr = bus_wr && prot_ok;
  wire [31:0] mask_w = wmask(bus_in);
  wire [31:0] b_width_mask = 32'h0000_0003;

  // read mux over the 32-bit register pair
  logic [31:0] rd_word;
  always_comb begin
    rd_word = RST_WORD;
    case ({bus_in.addr[15:1], 1'b0})
      OFS_A_CONTROL: rd_word = a_control;
      OFS_A_QUAL_LO: rd_word = a_qual_lo;
      OFS_A_QUAL_HI: rd_word = a_qual_hi;
      OFS_A_FUNC_LO: rd_word = a_func_lo;
      OFS_A_FUNC_HI: rd_word = a_func_hi;
      OFS_A_DIR: rd_word = a_dir;
      OFS_A_PULLUP_OFF: rd_word = a_pullup_off;
      OFS_B_CONTROL: rd_word = b_control;
      OFS_B_QUAL_LO: rd_word = b_qual_lo;
      OFS_B_FUNC_LO: rd_word = b_func_lo;
      OFS_B_DIR: rd_word = b_dir;
      OFS_B_PULLUP_OFF: rd_word = b_pullup_off;
      OFS_A_DATA: rd_word = pin_level[31:0];
      OFS_B_DATA: rd_word = {30'h0000_0000, pin_level[33:32]};
      OFS_IRQ1_SEL: rd_word = {27'h000_0000, irq1_sel};
      OFS_IRQ2_SEL: rd_word = {27'h000_0000, irq2_sel};
      OFS_WAKE_SEL: rd_word = wakeup_sel;
      default: rd_word = RST_WORD;
    endcase
    // the one-word select registers sit at odd and even word addresses
    if (bus_in.addr == OFS_IRQ2_SEL) begin
      rd_word = {27'h000_0000, irq2_sel};
    end
    if (bus_in.addr == OFS_NMI_SEL) begin
      rd_word = {27'h000_0000, nmi_sel};
    end
    if (bus_in.addr == OFS_IRQ1_SEL) begin
      rd_word = {27'h000_0000, irq1_sel};
    end
  end

  wire [31:0] rd_lane = bus_in.wide ? rd_word :
                        (bus_in.addr[0] && bus_in.addr != OFS_IRQ2_SEL) ?
                        {16'h0000, rd_word[31:16]} : {16'h0000, rd_word[15:0]};

  // bus answer: one cycle after the request
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bus_ack_out <= 1'b0;
      bus_rdata_out <= RST_WORD;
    end else if (clk_en_in) begin
      bus_ack_out <= bus_in.req;
      bus_rdata_out <= (bus_in.req && !bus_in.wr) ? rd_lane : RST_WORD;
    end
  end

  // protected configuration registers
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      a_control <= RST_WORD;
      a_qual_lo <= RST_WORD;
      a_qual_hi <= RST_WORD;
      a_func_lo <= RST_WORD;
      a_func_hi <= RST_WORD;
      a_dir <= RST_WORD;
      a_pullup_off <= RST_PULLUP_OFF;
      b_control <= RST_WORD;
      b_qual_lo <= RST_WORD;
      b_func_lo <= RST_WORD;
      b_dir <= RST_WORD;
      b_pullup_off <= RST_PULLUP_OFF;
    end else if (cfg_wr) begin
      if (hit(bus_in, OFS_A_CONTROL)) a_control <= merge(a_control, bus_in);
      if (hit(bus_in, OFS_A_QUAL_LO)) a_qual_lo <= merge(a_qual_lo, bus_in);
      if (hit(bus_in, OFS_A_QUAL_HI)) a_qual_hi <= merge(a_qual_hi, bus_in);
      if (hit(bus_in, OFS_A_FUNC_LO)) a_func_lo <= merge(a_func_lo, bus_in);
      if (hit(bus_in, OFS_A_FUNC_HI)) a_func_hi <= merge(a_func_hi, bus_in);
      if (hit(bus_in, OFS_A_DIR)) a_dir <= merge(a_dir, bus_in);
      if (hit(bus_in, OFS_A_PULLUP_OFF)) a_pullup_off <= merge(a_pullup_off, bus_in);
      if (hit(bus_in, OFS_B_CONTROL)) b_control <= merge(b_control, bus_in);
      if (hit(bus_in, OFS_B_QUAL_LO)) b_qual_lo <= merge(b_qual_lo, bus_in) & 32'h0000_000F;
      if (hit(bus_in, OFS_B_FUNC_LO)) b_func_lo <= merge(b_func_lo, bus_in) & 32'h0000_000F;
      if (hit(bus_in, OFS_B_DIR)) b_dir <= merge(b_dir, bus_in) & b_width_mask;
      if (hit(bus_in, OFS_B_PULLUP_OFF)) begin
        b_pullup_off <= merge(b_pullup_off, bus_in) & b_width_mask;
      end
    end
  end

  // interrupt and wake selects, also protected
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq1_sel <= RST_PIN_SEL;
      irq2_sel <= RST_PIN_SEL;
      nmi_sel <= RST_PIN_SEL;
      wakeup_sel <= RST_WORD;
    end else if (cfg_wr) begin
      if (bus_in.addr == OFS_IRQ1_SEL) irq1_sel <= bus_in.wdata[4:0];
      if (bus_in.addr == OFS_IRQ2_SEL) irq2_sel <= bus_in.wdata[4:0];
      if (bus_in.addr == OFS_NMI_SEL) nmi_sel <= bus_in.wdata[4:0];
      if (hit(bus_in, OFS_WAKE_SEL)) wakeup_sel <= merge(wakeup_sel, bus_in);
    end
  end

  // output latches: no unlock needed; set wins over clear within one access
  wire a_dat_w = bus_wr && hit(bus_in, OFS_A_DATA);
  wire a_set_w = bus_wr && hit(bus_in, OFS_A_SET);
  wire a_clr_w = bus_wr && hit(bus_in, OFS_A_CLEAR);
  wire a_inv_w = bus_wr && hit(bus_in, OFS_A_INVERT);
  wire b_dat_w = bus_wr && hit(bus_in, OFS_B_DATA);
  wire b_set_w = bus_wr && hit(bus_in, OFS_B_SET);
  wire b_clr_w = bus_wr && hit(bus_in, OFS_B_CLEAR);
  wire b_inv_w = bus_wr && hit(bus_in, OFS_B_INVERT);
  wire [31:0] next_a_latch = a_dat_w ? merge(a_latch, bus_in) :
                             a_set_w ? (a_latch | mask_w) :
                             a_clr_w ? (a_latch & ~mask_w) :
                             a_inv_w ? (a_latch ^ mask_w) : a_latch;
  wire [31:0] next_b_latch = (b_dat_w ? merge(b_latch, bus_in) :
                              b_set_w ? (b_latch | mask_w) :
                              b_clr_w ? (b_latch & ~mask_w) :
                              b_inv_w ? (b_latch ^ mask_w) : b_latch) & b_width_mask;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      a_latch <= RST_WORD;
      b_latch <= RST_WORD;
    end else if (clk_en_in) begin
      a_latch <= next_a_latch;
      b_latch <= next_b_latch;
    end
  end

  // pin synchroniser; level changes once stages two and three agree
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync1 <= 34'h0_0000_0000;
      sync2 <= 34'h0_0000_0000;
      sync3 <= 34'h0_0000_0000;
      pin_level <= 34'h0_0000_0000;
    end else if (clk_en_in) begin
      sync1 <= pin_in;
      sync2 <= sync1;
      sync3 <= sync2;
      pin_level <= (sync2 & sync3) | (pin_level & (sync2 | sync3));
    end
  end

  // per-pin function multiplexer
  wire [67:0] func_all = {b_func_lo[3:0], a_func_hi, a_func_lo};
  wire [33:0] dir_all = {b_dir[1:0], a_dir};
  wire [33:0] latch_all = {b_latch[1:0], a_latch};
  wire [33:0] pud_all = {b_pullup_off[1:0], a_pullup_off};
  logic [33:0] mux_out, mux_oe;
  always_comb begin
    mux_out = 34'h0_0000_0000;
    mux_oe = 34'h0_0000_0000;
    for (int i = 0; i < PIN_COUNT; i++) begin
      case (pin_function_t'(func_all[2*i +: 2]))
        FN_PLAIN_IO: begin
          mux_out[i] = latch_all[i];
          mux_oe[i] = dir_all[i];
        end
        FN_PERIPH_1: begin
          mux_out[i] = periph_in[i].out_val[0];
          mux_oe[i] = periph_in[i].out_en[0];
        end
        FN_PERIPH_2: begin
          mux_out[i] = periph_in[i].out_val[1];
          mux_oe[i] = periph_in[i].out_en[1];
        end
        FN_PERIPH_3: begin
          mux_out[i] = periph_in[i].out_val[2];
          mux_oe[i] = periph_in[i].out_en[2];
        end
        default: begin
          mux_out[i] = 1'b0;
          mux_oe[i] = 1'b0;
        end
      endcase
      // two-wire pins in a peripheral function only pull low
      if ((i == TWO_WIRE_PIN_A || i == TWO_WIRE_PIN_B) && func_all[2*i +: 2] != 2'b00) begin
        mux_oe[i] = mux_oe[i] & ~mux_out[i];
        mux_out[i] = 1'b0;
      end
    end
  end

  // registered outputs
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_out <= 34'h0_0000_0000;
      pin_oe_out <= 34'h0_0000_0000;
      pullup_en_out <= 34'h3_FFFF_FFFF;
      periph_pin_level_out <= 34'h0_0000_0000;
      qual_sel_lo_out <= 34'h0_0000_0000;
      qual_sel_hi_out <= 34'h0_0000_0000;
      port_control_out <= 64'h0;
      external_interrupt_one_out <= 1'b0;
      external_interrupt_two_out <= 1'b0;
      external_nonmaskable_interrupt_out <= 1'b0;
      low_power_wake_mask_out <= RST_WORD;
    end else if (clk_en_in) begin
      pin_out <= mux_out;
      pin_oe_out <= mux_oe;
      pullup_en_out <= ~pud_all;
      periph_pin_level_out <= pin_level;
      for (int j = 0; j < 16; j++) begin
        qual_sel_lo_out[j] <= a_qual_lo[2*j];
        qual_sel_hi_out[j] <= a_qual_lo[2*j+1];
        qual_sel_lo_out[16+j] <= a_qual_hi[2*j];
        qual_sel_hi_out[16+j] <= a_qual_hi[2*j+1];
      end
      qual_sel_lo_out[33:32] <= {b_qual_lo[2], b_qual_lo[0]};
      qual_sel_hi_out[33:32] <= {b_qual_lo[3], b_qual_lo[1]};
      port_control_out <= {b_control, a_control};
      external_interrupt_one_out <= pin_level[irq1_sel];
      external_interrupt_two_out <= pin_level[irq2_sel];
      external_nonmaskable_interrupt_out <= pin_level[nmi_sel];
      low_power_wake_mask_out <= wakeup_sel & pin_level[31:0];
    end
  end
endmodule // pin_port

// ### verilog/pin_port_pkg.sv
// package for the pin multiplexer and data port: map, fields, carriers
// What this block does
// - each pin routes own I/O or peripheral
// - selector zero is plain I/O, default
// - software drives and samples each pin alone
// - 34 pins, port A 0-31, port B rest
// - accept 32-bit and 16-bit bus accesses
// - data write sets latch, read returns pin
// - data, set, clear, invert need no unlock
// - interrupt and wake selects need unlock
// - port A set, clear, invert locations
// - per-pin pull-up disable per port
// - per-pin direction per port
// - qualification per pin, two port A registers
// - two interrupts and nonmaskable pick A pin
// - per-pin wake selection on port A
// - two-wire pins use open-drain mux in a peripheral function
package pin_port_pkg;
  localparam int ADDR_W = 16;
  localparam int PIN_COUNT = 34;
  localparam int PORT_B_PINS = 2;
  // word offsets (each unit is a 16-bit word)
  localparam logic [15:0] OFS_A_CONTROL = 16'h6F80;
  localparam logic [15:0] OFS_A_QUAL_LO = 16'h6F82;
  localparam logic [15:0] OFS_A_QUAL_HI = 16'h6F84;
  localparam logic [15:0] OFS_A_FUNC_LO = 16'h6F86;
  localparam logic [15:0] OFS_A_FUNC_HI = 16'h6F88;
  localparam logic [15:0] OFS_A_DIR = 16'h6F8A;
  localparam logic [15:0] OFS_A_PULLUP_OFF = 16'h6F8C;
  localparam logic [15:0] OFS_B_CONTROL = 16'h6F90;
  localparam logic [15:0] OFS_B_QUAL_LO = 16'h6F92;
  localparam logic [15:0] OFS_B_QUAL_HI = 16'h6F94;
  localparam logic [15:0] OFS_B_FUNC_LO = 16'h6F96;
  localparam logic [15:0] OFS_B_FUNC_HI = 16'h6F98;
  localparam logic [15:0] OFS_B_DIR = 16'h6F9A;
  localparam logic [15:0] OFS_B_PULLUP_OFF = 16'h6F9C;
  localparam logic [15:0] OFS_A_DATA = 16'h6FC0;
  localparam logic [15:0] OFS_A_SET = 16'h6FC2;
  localparam logic [15:0] OFS_A_CLEAR = 16'h6FC4;
  localparam logic [15:0] OFS_A_INVERT = 16'h6FC6;
  localparam logic [15:0] OFS_B_DATA = 16'h6FC8;
  localparam logic [15:0] OFS_B_SET = 16'h6FCA;
  localparam logic [15:0] OFS_B_CLEAR = 16'h6FCC;
  localparam logic [15:0] OFS_B_INVERT = 16'h6FCE;
  localparam logic [15:0] OFS_IRQ1_SEL = 16'h6FE0;
  localparam logic [15:0] OFS_IRQ2_SEL = 16'h6FE1;
  localparam logic [15:0] OFS_NMI_SEL = 16'h6FE2;
  localparam logic [15:0] OFS_WAKE_SEL = 16'h6FE8;
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [4:0] RST_PIN_SEL = 5'h00;
  // pin-select field is bits 4:0 of the 16-bit select registers
  localparam int PIN_SEL_W = 5;
  // pull-up disable reset value: pull-ups on
  localparam logic [31:0] RST_PULLUP_OFF = 32'h0000_0000;

  typedef enum logic [1:0] {
    FN_PLAIN_IO = 2'b00,
    FN_PERIPH_1 = 2'b01,
    FN_PERIPH_2 = 2'b10,
    FN_PERIPH_3 = 2'b11
  } pin_function_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK = 2'b01
  } bus_state_t;

  // processor bus request
  typedef struct packed {
    logic req;
    logic wr;
    logic wide;
    logic [15:0] addr;
    logic [31:0] wdata;
  } bus_req_t;

  // per-pin peripheral signals, three selections each
  typedef struct packed {
    logic [2:0] out_val;
    logic [2:0] out_en;
  } periph_pin_t;
endpackage
